// ==== rtl/isc_fifo.sv ====
`timescale 1ns/100ps
module isc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic CLK_SYS_I,
    input wire logic RST_N_I,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    wire full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    wire empty = wr_ptr == rd_ptr;
    wire push = in_valid_i && !full;
    wire pop = out_ready_i && !empty;
    assign in_ready_o = !full;
    assign out_valid_o = !empty;
    assign out_data_o = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge CLK_SYS_I) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) wr_ptr <= wr_ptr + 1'b1;
            if (pop) rd_ptr <= rd_ptr + 1'b1;
        end
    end
endmodule : isc_fifo

// ==== rtl/isc_pkg.sv ====
package isc_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int SCL_MAX_HZ = 400_000;
    // shortest scl half period in system cycles, floor
    localparam int SCL_HALF_CYC = CLK_HZ / (2 * SCL_MAX_HZ);
    localparam int FILT_LEN = 3;
    localparam logic [4:0] ADDR_FIXED = 5'h0e;
    localparam logic [15:0] PLL_FIRST = 16'hf000;
    localparam logic [15:0] PLL_LAST = 16'hf004;
    localparam logic [15:0] REG_BASE = 16'hf000;
    localparam logic [2:0] LEN_REG = 3'h2;
    localparam logic [2:0] LEN_MEM = 3'h4;
    localparam int FIFO_DEPTH = 16;
    localparam int DATA_W = 8;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_SUBH = 3'b010,
        ST_SUBL = 3'b011,
        ST_WDATA = 3'b100,
        ST_RDATA = 3'b101,
        ST_MACK = 3'b110
    } isc_state_e;

    // one received write byte with its location
    typedef struct packed {
        logic [15:0] sub;
        logic [2:0] idx;
        logic [7:0] data;
    } isc_wbyte_s;
endpackage : isc_pkg

// ==== rtl/isc_slave.sv ====
`timescale 1ns/100ps
module isc_slave (
    input wire logic CLK_SYS_I,
    input wire logic RST_N_I,
    input wire logic SCL_I,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE_O,
    input wire logic SELECT_OR_ADDR_STRAP_LOW_I,
    input wire logic SERIAL_IN_OR_ADDR_STRAP_HIGH_I,
    input wire logic PLL_LOCKED_I,
    output logic WR_VALID_O,
    input wire logic WR_READY_I,
    output isc_pkg::isc_wbyte_s WR_DATA_O,
    output logic [15:0] RD_SUB_O,
    output logic [2:0] RD_IDX_O,
    output logic RD_REQ_O,
    input wire logic [7:0] RD_DATA_I,
    output logic BUSY_O
);
    // synchronisers: first stage only feeds second
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic [1:0] strap_lo_sync;
    logic [1:0] strap_hi_sync;
    logic [isc_pkg::FILT_LEN-1:0] scl_hist;
    logic [isc_pkg::FILT_LEN-1:0] sda_hist;
    logic scl_f;
    logic sda_f;
    logic [1:0] strap;
    isc_pkg::isc_state_e state;
    isc_pkg::isc_state_e next_state;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [15:0] sub;
    logic [2:0] idx;
    logic ack_phase;
    logic ack_ok;
    logic rd_mode;
    logic drive_low;
    logic fifo_in_ready;

    // filter: a level is accepted after FILT_LEN equal samples
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            strap_lo_sync <= 2'h0;
            strap_hi_sync <= 2'h0;
            scl_hist <= '1;
            sda_hist <= '1;
            scl_f <= 1'b1;
            sda_f <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[0], SCL_I};
            sda_sync <= {sda_sync[0], SDA_I};
            strap_lo_sync <= {strap_lo_sync[0], SELECT_OR_ADDR_STRAP_LOW_I};
            strap_hi_sync <= {strap_hi_sync[0],
                              SERIAL_IN_OR_ADDR_STRAP_HIGH_I};
            scl_hist <= {scl_hist[isc_pkg::FILT_LEN-2:0], scl_sync[1]};
            sda_hist <= {sda_hist[isc_pkg::FILT_LEN-2:0], sda_sync[1]};
            // three samples is far shorter than any legal scl half period
            if (&scl_hist) scl_f <= 1'b1;
            else if (~|scl_hist) scl_f <= 1'b0;
            if (&sda_hist) sda_f <= 1'b1;
            else if (~|sda_hist) sda_f <= 1'b0;
        end
    end

    // straps are hardwired, so re-sampling them each cycle is harmless
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) strap <= 2'h0;
        else strap <= {strap_hi_sync[1], strap_lo_sync[1]};
    end

    logic scl_d;
    logic sda_d;
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_f;
            sda_d <= sda_f;
        end
    end

    wire scl_rise = scl_f && !scl_d;
    wire scl_fall = !scl_f && scl_d;
    wire start_det = scl_f && scl_d && sda_d && !sda_f;
    wire stop_det = scl_f && scl_d && !sda_d && sda_f;

    function automatic logic [2:0] word_len(input logic [15:0] a);
        word_len = (a >= isc_pkg::REG_BASE) ? isc_pkg::LEN_REG
                                            : isc_pkg::LEN_MEM;
    endfunction : word_len

    function automatic logic sub_ok(input logic [15:0] a, input logic lk);
        sub_ok = lk || (a >= isc_pkg::PLL_FIRST && a <= isc_pkg::PLL_LAST);
    endfunction : sub_ok

    // at the 8th rise the last bit is still on the line, not in shreg
    wire [7:0] rx_byte = {shreg[6:0], sda_f};
    // address ack slot of a read: rd_mode is not yet set there
    wire rd_next = rd_mode || state == isc_pkg::ST_RDATA;
    wire addr_match = rx_byte[7:3] == isc_pkg::ADDR_FIXED
                      && rx_byte[2:1] == strap;
    wire [15:0] sub_rx = {sub[15:8], rx_byte};
    wire last_of_word = (idx + 3'h1) >= word_len(sub);
    wire [15:0] sub_adv = last_of_word ? sub + 16'h1 : sub;
    wire [2:0] idx_adv = last_of_word ? 3'h0 : idx + 3'h1;
    // a full write fifo withholds the acknowledge rather than lose a byte
    wire wr_ack = sub_ok(sub, PLL_LOCKED_I) && fifo_in_ready;

    // byte complete: evaluated on 8th scl rise, acts on the ack slot
    always_comb begin
        next_state = state;
        if (state == isc_pkg::ST_ADDR) begin
            next_state = rx_byte[0] ? isc_pkg::ST_RDATA
                                    : isc_pkg::ST_SUBH;
        end else if (state == isc_pkg::ST_SUBH) begin
            next_state = isc_pkg::ST_SUBL;
        end else if (state == isc_pkg::ST_SUBL) begin
            next_state = isc_pkg::ST_WDATA;
        end
    end

    wire byte_done = scl_rise && bit_cnt == 4'h7 && !ack_phase
                     && !rd_mode;
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state <= isc_pkg::ST_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            sub <= 16'h0000;
            idx <= 3'h0;
            ack_phase <= 1'b0;
            ack_ok <= 1'b0;
            rd_mode <= 1'b0;
            drive_low <= 1'b0;
        end else if (start_det) begin
            state <= isc_pkg::ST_ADDR;
            bit_cnt <= 4'h0;
            ack_phase <= 1'b0;
            rd_mode <= 1'b0;
            drive_low <= 1'b0;
            idx <= 3'h0;
        end else if (stop_det) begin
            state <= isc_pkg::ST_IDLE;
            drive_low <= 1'b0;
            rd_mode <= 1'b0;
            ack_phase <= 1'b0;
        end else if (state != isc_pkg::ST_IDLE) begin
            if (scl_rise && !ack_phase) begin
                // in a read shreg holds outgoing data and must not take sda
                if (!rd_mode) shreg <= {shreg[6:0], sda_f};
                bit_cnt <= bit_cnt + 4'h1;
            end
            if (scl_rise && ack_phase && rd_mode) begin
                // master nack ends the read; ack loads next byte
                if (sda_f) state <= isc_pkg::ST_IDLE;
            end
            if (scl_fall && bit_cnt == 4'h8 && !ack_phase) begin
                ack_phase <= 1'b1;
                bit_cnt <= 4'h0;
                if (rd_mode) begin
                    drive_low <= 1'b0;
                    sub <= sub_adv;
                    idx <= idx_adv;
                end else begin
                    drive_low <= ack_ok;
                    if (!ack_ok) state <= isc_pkg::ST_IDLE;
                end
            end else if (scl_fall && ack_phase) begin
                ack_phase <= 1'b0;
                drive_low <= rd_next ? !RD_DATA_I[7] : 1'b0;
                shreg <= rd_next ? {RD_DATA_I[6:0], 1'b0} : shreg;
                if (state == isc_pkg::ST_RDATA) rd_mode <= 1'b1;
            end else if (scl_fall && rd_mode && bit_cnt != 4'h0) begin
                drive_low <= !shreg[7];
                shreg <= {shreg[6:0], 1'b0};
            end
            if (byte_done) begin
                unique case (state)
                    isc_pkg::ST_ADDR: ack_ok <= addr_match;
                    isc_pkg::ST_SUBH: ack_ok <= 1'b1;
                    isc_pkg::ST_SUBL: ack_ok <= sub_ok(sub_rx, PLL_LOCKED_I);
                    isc_pkg::ST_WDATA: ack_ok <= wr_ack;
                    default: ack_ok <= 1'b1;
                endcase
            end
            if (scl_rise && bit_cnt == 4'h7 && !ack_phase && !rd_mode) begin
                state <= next_state;
                if (state == isc_pkg::ST_SUBH) sub <= {rx_byte, 8'h00};
                if (state == isc_pkg::ST_SUBL) begin
                    sub <= sub_rx;
                    idx <= 3'h0;
                end
                if (state == isc_pkg::ST_WDATA && wr_ack) begin
                    sub <= sub_adv;
                    idx <= idx_adv;
                end
            end
            if (rd_mode && scl_rise && bit_cnt == 4'h7) bit_cnt <= 4'h8;
        end
    end

    // shift register holds the partial byte; sample the whole byte here
    wire [7:0] wr_byte = rx_byte;
    isc_pkg::isc_wbyte_s wr_in;
    assign wr_in = '{sub: sub, idx: idx, data: wr_byte};
    wire wr_push = byte_done && state == isc_pkg::ST_WDATA && wr_ack;

    isc_fifo #(
        .WIDTH($bits(isc_pkg::isc_wbyte_s)),
        .DEPTH(isc_pkg::FIFO_DEPTH)
    ) u_fifo (
        .CLK_SYS_I(CLK_SYS_I),
        .RST_N_I(RST_N_I),
        .in_valid_i(wr_push),
        .in_ready_o(fifo_in_ready),
        .in_data_i(wr_in),
        .out_valid_o(WR_VALID_O),
        .out_ready_i(WR_READY_I),
        .out_data_o(WR_DATA_O)
    );

    assign SDA_O = 1'b0;
    assign SDA_OE_O = drive_low;
    assign RD_SUB_O = sub;
    assign RD_IDX_O = idx;
    assign RD_REQ_O = rd_mode && ack_phase;
    assign BUSY_O = state != isc_pkg::ST_IDLE;

    chk_stop_idle: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        stop_det |=> state == isc_pkg::ST_IDLE)
        else $error("stop did not return to idle");
    chk_start_addr: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        start_det |=> state == isc_pkg::ST_ADDR && !SDA_OE_O)
        else $error("start did not enter address phase");
    chk_nack_release: assert property (@(posedge CLK_SYS_I)
        disable iff (!RST_N_I)
        (scl_fall && bit_cnt == 4'h8 && !ack_phase && !rd_mode && !ack_ok
         && !start_det && !stop_det) |=> !SDA_OE_O)
        else $error("sda driven without acknowledge");
    chk_addr_ack: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        (byte_done && state == isc_pkg::ST_ADDR && !start_det && !stop_det)
        |=> ack_ok == $past(addr_match))
        else $error("address match wrong");
    chk_push_ack: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        wr_push |-> fifo_in_ready)
        else $error("byte pushed into full fifo");
    chk_lock_gate: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        (wr_push && !PLL_LOCKED_I) |-> sub >= isc_pkg::PLL_FIRST
        && sub <= isc_pkg::PLL_LAST)
        else $error("write outside clock setup before lock");
    chk_idx_bound: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        idx < isc_pkg::LEN_MEM)
        else $error("byte index beyond word");
    chk_sub_step: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        (wr_push && last_of_word && !start_det && !stop_det)
        |=> sub == $past(sub) + 16'h1)
        else $error("subaddress did not advance");
    cov_write: cover property (@(posedge CLK_SYS_I) wr_push);
    cov_read: cover property (@(posedge CLK_SYS_I) RD_REQ_O);
    cov_nack: cover property (@(posedge CLK_SYS_I)
        byte_done && state == isc_pkg::ST_ADDR && !addr_match);
endmodule : isc_slave

// ==== sim/i2c_slave_control_port_test.sv ====
`timescale 1ns/100ps
module i2c_slave_control_port_test;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic strap_low = 1'b0;
    logic strap_high = 1'b0;
    logic pll_locked = 1'b0;
    logic wr_ready = 1'b0;
    logic [7:0] rd_data = 8'h00;
    logic stall = 1'b0;
    logic scl, sda_low, sda_o, sda_oe, wr_valid, rd_req, busy;
    logic [15:0] rd_sub;
    logic [2:0] rd_idx;
    logic [6:0] addr;
    isc_pkg::isc_wbyte_s wr_data;
    isc_pkg::isc_wbyte_s exp_q[$];
    int failures = 0;
    int tests_run = 0;
    wire sda = ~(sda_low | (sda_oe & ~sda_o));

    isc_bus_master u_mst (.clk_i(clk_sys), .sda_i(sda), .scl_o(scl),
        .sda_low_o(sda_low));
    isc_slave u_dut (.CLK_SYS_I(clk_sys), .RST_N_I(rst_n), .SCL_I(scl),
        .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_O(sda_oe),
        .SELECT_OR_ADDR_STRAP_LOW_I(strap_low),
        .SERIAL_IN_OR_ADDR_STRAP_HIGH_I(strap_high),
        .PLL_LOCKED_I(pll_locked), .WR_VALID_O(wr_valid),
        .WR_READY_I(wr_ready), .WR_DATA_O(wr_data), .RD_SUB_O(rd_sub),
        .RD_IDX_O(rd_idx), .RD_REQ_O(rd_req), .RD_DATA_I(rd_data),
        .BUSY_O(busy));

    initial forever #5 clk_sys = ~clk_sys;

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic conclude();
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude

    function automatic logic [7:0] rd_fn(logic [15:0] s, logic [2:0] i);
        return s[7:0] ^ {i, 5'h00} ^ 8'h3c;
    endfunction : rd_fn

    // memory side: read data follows the pointer, consumer stalls at random
    always @(posedge clk_sys) begin
        rd_data <= rd_fn(rd_sub, rd_idx);
        wr_ready <= stall ? 1'b0 : 1'($urandom);
        if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
            if (exp_q.size() == 0) check("extra fifo word", 32'h1, 32'h0);
            else check("fifo word", 32'(wr_data), 32'(exp_q.pop_front()));
        end
    end

    task automatic open(input logic [6:0] a, input logic rw, input logic e);
        logic ack;
        u_mst.start();
        u_mst.wbyte({a, rw}, ack);
        check("address ack", 32'(ack), 32'(e));
    endtask : open

    task automatic send(input logic [7:0] d, input logic e, string what);
        logic ack;
        u_mst.wbyte(d, ack);
        check(what, 32'(ack), 32'(e));
    endtask : send

    task automatic wr(input logic [15:0] sub, input int n, input int n_ok);
        logic [15:0] s;
        logic [7:0] d;
        int idx;
        s = sub;
        idx = 0;
        open(addr, 1'b0, 1'b1);
        send(sub[15:8], 1'b1, "sub high ack");
        send(sub[7:0], 1'b1, "sub low ack");
        for (int k = 0; k < n; k++) begin
            d = 8'($urandom);
            if (k < n_ok) exp_q.push_back({s, 3'(idx), d});
            send(d, k < n_ok, "data ack");
            idx++;
            if (idx == (s >= 16'hf000 ? 2 : 4)) begin
                idx = 0;
                s++;
            end
        end
        u_mst.stop();
    endtask : wr

    initial begin
        logic [7:0] d;
        logic [6:0] masks [3];
        void'($urandom(32'h11f844b8));
        {strap_high, strap_low} = 2'($urandom);
        addr = {5'h0e, strap_high, strap_low};
        masks = '{7'h01, 7'h02, 7'h10};
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (10) @(posedge clk_sys);
        check("idle busy", 32'(busy), 32'h0);
        check("idle sda drive", 32'(sda_oe), 32'h0);
        for (int i = 0; i < 3; i++) begin
            open(addr ^ masks[i], 1'b0, 1'b0);
            u_mst.stop();
        end
        wr(16'hf003, 2, 2);
        open(addr, 1'b0, 1'b1);
        send(8'hf0, 1'b1, "sub high ack");
        send(8'h05, 1'b0, "sub low refused");
        check("idle after refusal", 32'(busy), 32'h0);
        u_mst.stop();
        open(addr, 1'b0, 1'b1);
        send(8'hf0, 1'b1, "sub high ack");
        check("busy mid frame", 32'(busy), 32'h1);
        u_mst.stop();
        repeat (20) @(posedge clk_sys);
        check("idle after early stop", 32'(busy), 32'h0);
        open(addr, 1'b0, 1'b1);
        send(8'hf0, 1'b1, "sub high ack");
        open(addr ^ 7'h10, 1'b0, 1'b0);
        u_mst.stop();
        // reset lands in mid frame; the bus is then closed normally
        open(addr, 1'b0, 1'b1);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        check("reset busy", 32'(busy), 32'h0);
        check("reset sda drive", 32'(sda_oe), 32'h0);
        check("reset fifo", 32'(wr_valid), 32'h0);
        rst_n <= 1'b1;
        u_mst.stop();
        pll_locked <= 1'b1;
        stall <= 1'b1;
        repeat (4) @(posedge clk_sys);
        // burst stays inside the memory region below the registers
        wr(16'h00fe, isc_pkg::FIFO_DEPTH + 1, isc_pkg::FIFO_DEPTH);
        stall <= 1'b0;
        for (int i = 0; i < 400 && exp_q.size() != 0; i++) @(posedge clk_sys);
        repeat (4) @(posedge clk_sys);
        check("fifo drained", 32'(exp_q.size()), 32'h0);
        check("fifo empty", 32'(wr_valid), 32'h0);
        open(addr, 1'b0, 1'b1);
        send(8'hf0, 1'b1, "sub high ack");
        send(8'h10, 1'b1, "sub low ack");
        open(addr, 1'b1, 1'b1);
        for (int k = 0; k < 3; k++) begin
            u_mst.rbyte(k < 2, d);
            check("read byte", 32'(d), 32'(rd_fn(16'hf010 + 16'(k / 2),
                3'(k % 2))));
        end
        u_mst.stop();
        repeat (20) @(posedge clk_sys);
        check("idle after read", 32'(busy), 32'h0);
        conclude();
    end

    initial begin
        repeat (150000) @(posedge clk_sys);
        failures++;
        conclude();
    end
endmodule : i2c_slave_control_port_test

// ==== sim/isc_bus_master.sv ====
`timescale 1ns/100ps
module isc_bus_master #(
    parameter int QTR = 63
) (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    // scl rests high between frames, sda left to the pull-up
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic qw();
        repeat (QTR) @(posedge clk_i);
    endtask : qw
    task automatic start();
        sda_low_o <= 1'b0;
        qw();
        scl_o <= 1'b1;
        qw();
        sda_low_o <= 1'b1;
        qw();
        scl_o <= 1'b0;
        qw();
    endtask : start
    task automatic stop();
        sda_low_o <= 1'b1;
        qw();
        scl_o <= 1'b1;
        qw();
        sda_low_o <= 1'b0;
        qw();
    endtask : stop
    // data moves only while scl is low, sampled mid-high
    task automatic bit_io(input logic b, output logic s);
        sda_low_o <= ~b;
        qw();
        scl_o <= 1'b1;
        qw();
        s = sda_i;
        qw();
        scl_o <= 1'b0;
        qw();
    endtask : bit_io
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
        bit_io(1'b1, s);
        ack = ~s;
    endtask : wbyte
    task automatic rbyte(input logic mack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            d[i] = s;
        end
        bit_io(~mack, s);
    endtask : rbyte
endmodule : isc_bus_master
